// >>> verif/flash_status_and_protection_tb_top.sv
// Self-checking bench of the flash status and protection block.
`timescale 1ns/1ps
module flash_status_and_protection_tb_top;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic protect_pin_n = 1'b1;
	logic pause_pin_n = 1'b1;
	logic sclk, cs_n, si, so_data, so_oe, op_refused, quad_lanes_on, fast_mode_flag;
	logic [1:0] drive_strength;
	logic [2:0] security_lock_bits;
	logic [7:0] rd_v;
	flash_sr_pkg::array_op_t array_op;
	flash_sr_pkg::array_op_t last_op;
	int errors = 0;
	int comparisons = 0;
	int cycles = 0;
	int refusals = 0;
	int accepts = 0;
	always #5 sys_clk = ~sys_clk;
	// Busy lengths are shortened, yet kept longer than a frame so suspend can catch them.
	flash_status_and_protection #(.SR_CYC(400), .PROG_CYC(600), .ERASE_CYC(1000), .CNT_W(20)) DUT (
		.sys_clk(sys_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si),
		.protect_pin_n(protect_pin_n), .pause_pin_n(pause_pin_n), .so_data(so_data),
		.so_oe(so_oe), .array_op(array_op), .op_refused(op_refused),
		.drive_strength(drive_strength), .quad_lanes_on(quad_lanes_on),
		.security_lock_bits(security_lock_bits), .fast_mode_flag(fast_mode_flag));
	spi_host_model host (.sclk(sclk), .cs_n(cs_n), .si(si), .so_data(so_data), .so_oe(so_oe));
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (op_refused === 1'b1) begin
			refusals <= refusals + 1;
		end
		if (rst === 1'b0 && array_op.kind !== flash_sr_pkg::OP_NONE) begin
			accepts <= accepts + 1;
			last_op <= array_op;
		end
	end
	task automatic report_and_stop();
		$display("Comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// The output enable is sampled in the middle of the data byte and again after the frame.
	task automatic rc(input logic [7:0] cmd, input logic [7:0] exp, input string what);
		logic oe_mid;
		fork
			host.xfer('{cmd, 8'h00}, rd_v);
			begin
				#1500;
				oe_mid = so_oe;
			end
		join
		chk(what, exp, rd_v);
		chk("so_oe in read", 8'h01, {7'h0, oe_mid});
		chk("so_oe after read", 8'h00, {7'h0, so_oe});
	endtask : rc
	task automatic write_latch_flag();
		host.xfer('{flash_sr_pkg::CMD_WR_ON}, rd_v);
	endtask : write_latch_flag
	task automatic idle();
		for (int i = 0; i < 60; i++) begin
			host.xfer('{flash_sr_pkg::CMD_RD1, 8'h00}, rd_v);
			if (rd_v[0] === 1'b0) begin
				return;
			end
		end
		chk("idle wait", 8'h00, 8'h01);
	endtask : idle
	// Sends one frame, optionally behind a write enable, and counts acceptances and refusals.
	// Status writes raise no array request, so their acceptance shows only as the busy bit.
	task automatic op(input logic [7:0] tx[$], input logic en, input logic ok);
		int r0;
		int a0;
		logic arr;
		r0 = refusals;
		a0 = accepts;
		arr = (tx[0] != flash_sr_pkg::CMD_SW1) && (tx[0] != flash_sr_pkg::CMD_SW2) &&
			(tx[0] != flash_sr_pkg::CMD_SW3);
		if (en) begin
			write_latch_flag();
		end
		host.xfer(tx, rd_v);
		host.xfer('{flash_sr_pkg::CMD_RD1, 8'h00}, rd_v);
		chk("busy after frame", {7'h0, ok}, {7'h0, rd_v[0]});
		idle();
		chk("accepted", {7'h0, ok && arr}, 8'(accepts - a0));
		chk("refused", {7'h0, !ok}, 8'(refusals - r0));
	endtask : op
	task automatic pwr();
		@(negedge sys_clk) rst = 1'b1;
		repeat (8) @(negedge sys_clk);
		rst = 1'b0;
		repeat (4) @(negedge sys_clk);
	endtask : pwr
	initial begin
		wait (cycles == 90000);
		errors++;
		report_and_stop();
	end
	initial begin
		pwr();
		rc(flash_sr_pkg::CMD_RD1, 8'h00, "status low");
		rc(flash_sr_pkg::CMD_RD2, 8'h00, "status mid");
		rc(flash_sr_pkg::CMD_RD3, 8'h20, "status high");
		chk("controls", 8'h20, {1'b0, drive_strength, quad_lanes_on, security_lock_bits,
			fast_mode_flag});
		op('{flash_sr_pkg::CMD_SW1, 8'h04}, 1'b0, 1'b0);
		write_latch_flag();
		rc(flash_sr_pkg::CMD_RD1, 8'h02, "latch set");
		host.xfer('{flash_sr_pkg::CMD_WR_LOCK}, rd_v);
		rc(flash_sr_pkg::CMD_RD1, 8'h00, "latch cleared");
		write_latch_flag();
		host.xfer('{flash_sr_pkg::CMD_SW1, 8'h04}, rd_v);
		rc(flash_sr_pkg::CMD_RD1, 8'h07, "busy status");
		idle();
		rc(flash_sr_pkg::CMD_RD1, 8'h04, "protect level");
		op('{flash_sr_pkg::CMD_PAGE, 8'h7e, 8'h00, 8'h00, 8'ha5}, 1'b1, 1'b0);
		op('{flash_sr_pkg::CMD_PAGE, 8'h7d, 8'hff, 8'hff, 8'ha5}, 1'b1, 1'b1);
		chk("op kind", {4'h0, flash_sr_pkg::OP_PROG}, {4'h0, last_op.kind});
		chk("op addr", 8'h7d, last_op.addr[23:16]);
		op('{flash_sr_pkg::CMD_CHIP1}, 1'b1, 1'b0);
		op('{flash_sr_pkg::CMD_SW2, 8'h40}, 1'b1, 1'b1);
		rc(flash_sr_pkg::CMD_RD2, 8'h40, "invert set");
		op('{flash_sr_pkg::CMD_PAGE, 8'h7e, 8'h00, 8'h00, 8'h11}, 1'b1, 1'b1);
		op('{flash_sr_pkg::CMD_PAGE, 8'h00, 8'h00, 8'h00, 8'h11}, 1'b1, 1'b0);
		op('{flash_sr_pkg::CMD_SW1, 8'h1c}, 1'b1, 1'b1);
		op('{flash_sr_pkg::CMD_CHIP2}, 1'b1, 1'b1);
		chk("chip kind", {4'h0, flash_sr_pkg::OP_CHIP}, {4'h0, last_op.kind});
		op('{flash_sr_pkg::CMD_SW1, 8'h00}, 1'b1, 1'b1);
		op('{flash_sr_pkg::CMD_SECT, 8'h00, 8'h10, 8'h00}, 1'b1, 1'b0);
		op('{flash_sr_pkg::CMD_SW2, 8'h00}, 1'b1, 1'b1);
		op('{flash_sr_pkg::CMD_BLK32, 8'h01, 8'h00, 8'h00}, 1'b1, 1'b1);
		chk("erase kind", {4'h0, flash_sr_pkg::OP_ERASE}, {4'h0, last_op.kind});
		op('{flash_sr_pkg::CMD_BLK64, 8'h7f, 8'h00, 8'h00}, 1'b1, 1'b1);
		op('{flash_sr_pkg::CMD_CHIP1}, 1'b1, 1'b1);
		for (int d = 0; d < 4; d++) begin
			op('{flash_sr_pkg::CMD_SW3, {1'b1, 2'(d), 1'b0, 4'hf}}, 1'b1, 1'b1);
			rc(flash_sr_pkg::CMD_RD3, {1'b0, 2'(d), 5'h0}, "drive field");
			chk("drive pins", 8'(d), {6'h0, drive_strength});
		end
		op('{flash_sr_pkg::CMD_SW2, 8'h08}, 1'b1, 1'b1);
		op('{flash_sr_pkg::CMD_SW2, 8'h00}, 1'b1, 1'b1);
		rc(flash_sr_pkg::CMD_RD2, 8'h08, "lock bits kept");
		chk("lock pins", 8'h01, {5'h0, security_lock_bits});
		op('{flash_sr_pkg::CMD_SW2, 8'h0a}, 1'b1, 1'b1);
		chk("quad pin", 8'h01, {7'h0, quad_lanes_on});
		op('{flash_sr_pkg::CMD_SW2, 8'h08}, 1'b1, 1'b1);
		op('{flash_sr_pkg::CMD_SW1, 8'h80}, 1'b1, 1'b1);
		@(negedge sys_clk) protect_pin_n = 1'b0;
		op('{flash_sr_pkg::CMD_SW1, 8'h84}, 1'b1, 1'b0);
		@(negedge sys_clk) protect_pin_n = 1'b1;
		op('{flash_sr_pkg::CMD_SW1, 8'h84}, 1'b1, 1'b1);
		op('{flash_sr_pkg::CMD_SW1, 8'h04}, 1'b1, 1'b1);
		op('{flash_sr_pkg::CMD_SW2, 8'h09}, 1'b1, 1'b1);
		op('{flash_sr_pkg::CMD_SW1, 8'h00}, 1'b1, 1'b0);
		pwr();
		rc(flash_sr_pkg::CMD_RD2, 8'h00, "mode after power");
		op('{flash_sr_pkg::CMD_SW1, 8'h80}, 1'b1, 1'b1);
		op('{flash_sr_pkg::CMD_SW2, 8'h01}, 1'b1, 1'b1);
		op('{flash_sr_pkg::CMD_SW1, 8'h00}, 1'b1, 1'b0);
		pwr();
		write_latch_flag();
		host.xfer('{flash_sr_pkg::CMD_PAGE, 8'h00, 8'h01, 8'h00, 8'h55}, rd_v);
		host.xfer('{flash_sr_pkg::CMD_SUSP}, rd_v);
		rc(flash_sr_pkg::CMD_RD2, 8'h04, "program paused");
		host.xfer('{flash_sr_pkg::CMD_RESUME}, rd_v);
		rc(flash_sr_pkg::CMD_RD2, 8'h00, "resumed");
		idle();
		write_latch_flag();
		host.xfer('{flash_sr_pkg::CMD_SECT, 8'h00, 8'h20, 8'h00}, rd_v);
		host.xfer('{flash_sr_pkg::CMD_SUSP}, rd_v);
		rc(flash_sr_pkg::CMD_RD2, 8'h80, "erase paused");
		host.xfer('{flash_sr_pkg::CMD_RST_EN}, rd_v);
		host.xfer('{flash_sr_pkg::CMD_RST}, rd_v);
		rc(flash_sr_pkg::CMD_RD2, 8'h00, "after soft reset");
		host.xfer('{flash_sr_pkg::CMD_FAST_ON}, rd_v);
		rc(flash_sr_pkg::CMD_RD3, 8'h30, "fast mode");
		chk("fast pin", 8'h01, {7'h0, fast_mode_flag});
		host.xfer('{flash_sr_pkg::CMD_FAST_OFF}, rd_v);
		rc(flash_sr_pkg::CMD_RD3, 8'h20, "normal mode");
		chk("normal pin", 8'h00, {7'h0, fast_mode_flag});
		report_and_stop();
	end
endmodule : flash_status_and_protection_tb_top

// >>> verif/spi_host_model.sv
// Behavioural SPI host that frames flash commands in mode 0.
`timescale 1ns/1ps
module spi_host_model (
	// Serial pins.
	output logic sclk,
	output logic cs_n,
	output logic si,
	input wire logic so_data,
	input wire logic so_oe
);
	localparam realtime HALF = 62.5;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// The clock stands low between frames, and data in flips after each frame so a stale bit
	// never looks valid.
	task automatic xfer(input logic [7:0] tx[$], output logic [7:0] last);
		logic [7:0] sh;
		cs_n = 1'b0;
		foreach (tx[i]) begin
			for (int b = 7; b >= 0; b--) begin
				si = tx[i][b];
				#HALF;
				sclk = 1'b1;
				sh = {sh[6:0], so_data};
				#HALF;
				sclk = 1'b0;
			end
			last = sh;
		end
		#HALF;
		cs_n = 1'b1;
		si = ~si;
		#200;
	endtask : xfer
endmodule : spi_host_model

// >>> verilog/flash_sr_pkg.sv
// Constants, codes and status layout of the flash status and protection block.
// Functional notes
// - Status bit 0 is 1 while program, erase or status write runs.
// - Bit 1 mirrors the write latch; when 0, writes, programs and erases are ignored.
// - Five protect level bits are kept, changed only by status writes, select shielded area.
// - Program or erase aimed inside the shielded area is refused, array untouched.
// - Protect level writes apply only while the status lock is not engaged.
// - Full wipe runs only with low bits 000 and invert 0, or 111 and invert 1.
// - Invert set complements the shielded area: 000 shields all, 111 nothing.
// - Protect invert is a kept read/write bit at 14, default 0.
// - Lock mode 00 accepts writes after latch; 01 only while protect pin high.
// - Lock mode 10 refuses writes until power cycle, which returns mode to 00.
// - Lock mode 11 refuses every status write permanently; here power-up returns it to 00.
// - Quad lanes bit 9, default 0; when 1 the two control pins become data.
// - Three security lock bits default 0, set singly, never cleared; here power-up clears them.
// - Suspend sets erase paused bit 15 or program paused bit 10.
// - Paused bits clear on resume, on the software reset pair, on power cycle.
// - Fast mode flag at bit 20 reads 1 in fast mode, default 0.
// - Drive field 22:21 selects strength: full, three quarters default, half, quarter.
// - Invert clear: 000 shields nothing, 111 all, others fractions or top/bottom sectors.
// - Write latch clears on power-up, write lock, completed writes and software reset.
package flash_sr_pkg;
	localparam logic [7:0] CMD_WR_ON = 8'h06;
	localparam logic [7:0] CMD_WR_LOCK = 8'h04;
	localparam logic [7:0] CMD_RD1 = 8'h05;
	localparam logic [7:0] CMD_RD2 = 8'h35;
	localparam logic [7:0] CMD_RD3 = 8'h15;
	localparam logic [7:0] CMD_SW1 = 8'h01;
	localparam logic [7:0] CMD_SW2 = 8'h31;
	localparam logic [7:0] CMD_SW3 = 8'h11;
	localparam logic [7:0] CMD_PAGE = 8'h02;
	localparam logic [7:0] CMD_SECT = 8'h20;
	localparam logic [7:0] CMD_BLK32 = 8'h52;
	localparam logic [7:0] CMD_BLK64 = 8'hd8;
	localparam logic [7:0] CMD_CHIP1 = 8'h60;
	localparam logic [7:0] CMD_CHIP2 = 8'hc7;
	localparam logic [7:0] CMD_SUSP = 8'h75;
	localparam logic [7:0] CMD_RESUME = 8'h7a;
	localparam logic [7:0] CMD_RST_EN = 8'h66;
	localparam logic [7:0] CMD_RST = 8'h99;
	localparam logic [7:0] CMD_FAST_ON = 8'ha3;
	localparam logic [7:0] CMD_FAST_OFF = 8'hab;
	localparam logic [2:0] BYTES_SW = 3'h2;
	localparam logic [2:0] BYTES_ADDR = 3'h4;
	localparam logic [2:0] BYTES_PROG = 3'h5;
	localparam logic [22:0] ARRAY_TOP = 23'h7fffff;
	localparam logic [22:0] BIG_UNIT = 23'h010000;
	localparam logic [22:0] SMALL_UNIT = 23'h001000;
	localparam logic [22:0] SMALL_MAX = 23'h008000;
	localparam logic [2:0] BP_NONE = 3'h0;
	localparam logic [2:0] BP_ALL = 3'h7;
	localparam logic [1:0] DRV_DEFAULT = 2'h1;
	localparam logic [4:0] PIN_IDLE = 5'h1e;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01, ST_SR = 5'h02, ST_PROG = 5'h04, ST_ERASE = 5'h08, ST_PAUSE = 5'h10
	} phase_t;
	typedef enum logic [3:0] {
		OP_NONE = 4'h1, OP_PROG = 4'h2, OP_ERASE = 4'h4, OP_CHIP = 4'h8
	} op_kind_t;
	typedef struct packed {
		op_kind_t kind;
		logic [23:0] addr;
	} array_op_t;
	typedef struct packed {
		logic res_hi;
		logic [1:0] drive;
		logic fast;
		logic [3:0] res_mid;
		logic esus;
		logic cmp;
		logic [2:0] lb;
		logic psus;
		logic qe;
		logic lock_mode_high;
		logic lock_mode_low;
		logic [4:0] bp;
		logic write_latch_flag;
		logic write_in_progress;
	} status_t;
	localparam status_t SR_DEFAULT = '{drive: DRV_DEFAULT, default: '0};
endpackage : flash_sr_pkg

// >>> verilog/flash_status_and_protection.sv
// Status register, write protection and command gating of the serial flash.
`timescale 1ns/1ps
module flash_status_and_protection #(
	parameter int SR_CYC = 2000,
	parameter int PROG_CYC = 5000,
	parameter int ERASE_CYC = 8000,
	parameter int CNT_W = 20
) (
	// Clock and power-up reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Serial pins; the inputs are asynchronous to sys_clk, the outputs come from sys_clk flops.
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic si,
	input wire logic protect_pin_n,
	input wire logic pause_pin_n,
	output logic so_data,
	output logic so_oe,
	// Array side.
	output flash_sr_pkg::array_op_t array_op,
	output logic op_refused,
	// Controls taken from the status register.
	output logic [1:0] drive_strength,
	output logic quad_lanes_on,
	output logic [2:0] security_lock_bits,
	output logic fast_mode_flag
);
	if (CNT_W < 2 || CNT_W > 30 || SR_CYC < 1 || PROG_CYC < 1 || ERASE_CYC < 1 ||
		SR_CYC >= (1 << CNT_W) || PROG_CYC >= (1 << CNT_W) ||
		ERASE_CYC >= (1 << CNT_W)) begin : g_chk
		$error("flash_status_and_protection: busy counts do not fit CNT_W");
	end

	logic [4:0] s1_ff, s2_ff, s3_ff;
	logic [2:0] bits_ff, bytes_ff;
	logic [7:0] shift_ff, cmd_ff, data_ff, tx_ff;
	logic [23:0] addr_ff;
	logic so_ff, oe_ff, arm_ff, refused_ff;
	flash_sr_pkg::status_t sr_ff, status, wr;
	flash_sr_pkg::phase_t state_ff, nxt_state;
	flash_sr_pkg::array_op_t op_ff;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;

	// Pins pass two flops; the third stage only feeds edge detection.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s1_ff <= flash_sr_pkg::PIN_IDLE;
			s2_ff <= flash_sr_pkg::PIN_IDLE;
			s3_ff <= flash_sr_pkg::PIN_IDLE;
		end else begin
			s1_ff <= {pause_pin_n, protect_pin_n, si, cs_n, sclk};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	wire logic cs_s = s2_ff[1];
	wire logic si_s = s2_ff[2];
	// With quad lanes on, both control pins are data and lose their roles.
	wire logic hold_ok = sr_ff.qe | s2_ff[4];
	wire logic wp_level = sr_ff.qe | s2_ff[3];
	wire logic sck_rise = ~cs_s & hold_ok & s2_ff[0] & ~s3_ff[0];
	wire logic sck_fall = ~cs_s & hold_ok & ~s2_ff[0] & s3_ff[0];
	wire logic frame_end = cs_s & ~s3_ff[1];
	wire logic byte_done = sck_rise & (bits_ff == 3'h7);
	wire logic [7:0] new_byte = {shift_ff[6:0], si_s};
	wire logic [7:0] code_now = (bytes_ff == 3'h0) ? new_byte : cmd_ff;

	// Frame capture: command, three address bytes, and the first byte after the command as data.
	always_ff @(posedge sys_clk) begin
		if (rst || cs_s) begin
			bits_ff <= 3'h0;
			bytes_ff <= 3'h0;
		end else if (sck_rise) begin
			shift_ff <= new_byte;
			bits_ff <= bits_ff + 3'h1;
			if (bits_ff == 3'h7 && bytes_ff != 3'h7) begin
				bytes_ff <= bytes_ff + 3'h1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cmd_ff <= 8'h00;
			addr_ff <= 24'h000000;
			data_ff <= 8'h00;
		end else if (byte_done) begin
			case (bytes_ff)
				3'h0: cmd_ff <= new_byte;
				3'h1: addr_ff[23:16] <= new_byte;
				3'h2: addr_ff[15:8] <= new_byte;
				3'h3: addr_ff[7:0] <= new_byte;
				default: ;
			endcase
			if (bytes_ff == 3'h1) begin
				data_ff <= new_byte;
			end
		end
	end

	// Status read-back; reserved bits and the busy bit are built here.
	always_comb begin
		status = sr_ff;
		status.write_in_progress = (state_ff == flash_sr_pkg::ST_SR) ||
			(state_ff == flash_sr_pkg::ST_PROG) || (state_ff == flash_sr_pkg::ST_ERASE);
		status.res_hi = 1'b0;
		status.res_mid = 4'h0;
	end

	wire logic rd1 = code_now == flash_sr_pkg::CMD_RD1;
	wire logic rd2 = code_now == flash_sr_pkg::CMD_RD2;
	wire logic rd3 = code_now == flash_sr_pkg::CMD_RD3;
	wire logic [7:0] rd_byte = rd1 ? status[7:0] : rd2 ? status[15:8] : status[23:16];

	// Each completed byte reloads the status byte, so polling sees fresh busy state.
	always_ff @(posedge sys_clk) begin
		if (rst || cs_s) begin
			tx_ff <= 8'h00;
			so_ff <= 1'b0;
			oe_ff <= 1'b0;
		end else if (byte_done && (rd1 || rd2 || rd3)) begin
			tx_ff <= rd_byte;
			oe_ff <= 1'b1;
		end else if (sck_fall) begin
			so_ff <= tx_ff[7];
			tx_ff <= {tx_ff[6:0], 1'b0};
		end
	end

	// Decode of a completed frame; only byte-aligned frames execute.
	wire logic aligned = frame_end & (bits_ff == 3'h0) & (bytes_ff != 3'h0);
	wire logic c_is_sw = (cmd_ff == flash_sr_pkg::CMD_SW1) ||
		(cmd_ff == flash_sr_pkg::CMD_SW2) || (cmd_ff == flash_sr_pkg::CMD_SW3);
	wire logic is_sw = c_is_sw && (bytes_ff >= flash_sr_pkg::BYTES_SW);
	wire logic is_prog = (cmd_ff == flash_sr_pkg::CMD_PAGE) &&
		(bytes_ff >= flash_sr_pkg::BYTES_PROG);
	wire logic is_erase = ((cmd_ff == flash_sr_pkg::CMD_SECT) ||
		(cmd_ff == flash_sr_pkg::CMD_BLK32) || (cmd_ff == flash_sr_pkg::CMD_BLK64)) &&
		(bytes_ff >= flash_sr_pkg::BYTES_ADDR);
	wire logic is_chip = (cmd_ff == flash_sr_pkg::CMD_CHIP1) ||
		(cmd_ff == flash_sr_pkg::CMD_CHIP2);
	wire logic do_wren = aligned && cmd_ff == flash_sr_pkg::CMD_WR_ON && !status.write_in_progress;
	wire logic do_write_lock_cmd = aligned && cmd_ff == flash_sr_pkg::CMD_WR_LOCK;
	wire logic do_susp = aligned && cmd_ff == flash_sr_pkg::CMD_SUSP;
	wire logic do_resume = aligned && cmd_ff == flash_sr_pkg::CMD_RESUME;
	wire logic sw_reset = aligned && cmd_ff == flash_sr_pkg::CMD_RST && arm_ff;

	// Shielded-area decode over the 8 MB span.
	function automatic logic shielded(input logic [22:0] a, input logic [4:0] bp,
		input logic cmp);
		logic [22:0] size;
		logic hit;
		if (bp[4]) begin
			size = bp[2] ? flash_sr_pkg::SMALL_MAX :
				flash_sr_pkg::SMALL_UNIT << (bp[1:0] - 2'h1);
		end else begin
			size = flash_sr_pkg::BIG_UNIT << bp[2:0];
		end
		hit = bp[3] ? (a < size) : (a > (flash_sr_pkg::ARRAY_TOP - size));
		if (bp[2:0] == flash_sr_pkg::BP_NONE) begin
			hit = 1'b0;
		end else if (bp[2:0] == flash_sr_pkg::BP_ALL) begin
			hit = 1'b1;
		end
		return hit ^ cmp;
	endfunction : shielded

	wire logic prot = shielded(addr_ff[22:0], sr_ff.bp, sr_ff.cmp);
	wire logic can_write = sr_ff.write_latch_flag && (state_ff == flash_sr_pkg::ST_IDLE);
	wire logic lock_ok = ({sr_ff.lock_mode_high, sr_ff.lock_mode_low} == 2'h0) ||
		(({sr_ff.lock_mode_high, sr_ff.lock_mode_low} == 2'h1) && wp_level);
	wire logic chip_ok = (sr_ff.bp[2:0] == flash_sr_pkg::BP_NONE && !sr_ff.cmp) ||
		(sr_ff.bp[2:0] == flash_sr_pkg::BP_ALL && sr_ff.cmp);
	wire logic go_sw = aligned && is_sw && can_write && lock_ok;
	wire logic go_prog = aligned && is_prog && can_write && !prot;
	wire logic go_erase = aligned && is_erase && can_write && !prot;
	wire logic go_chip = aligned && is_chip && can_write && chip_ok;
	wire logic want = aligned && (is_sw || is_prog || is_erase || is_chip);
	wire logic busy_end = status.write_in_progress && (cnt_ff == '0) &&
		!(do_susp && state_ff != flash_sr_pkg::ST_SR);

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			flash_sr_pkg::ST_IDLE: begin
				if (go_sw) begin
					nxt_state = flash_sr_pkg::ST_SR;
					nxt_cnt = CNT_W'(SR_CYC - 1);
				end else if (go_prog) begin
					nxt_state = flash_sr_pkg::ST_PROG;
					nxt_cnt = CNT_W'(PROG_CYC - 1);
				end else if (go_erase || go_chip) begin
					nxt_state = flash_sr_pkg::ST_ERASE;
					nxt_cnt = CNT_W'(ERASE_CYC - 1);
				end
			end
			flash_sr_pkg::ST_SR, flash_sr_pkg::ST_PROG, flash_sr_pkg::ST_ERASE: begin
				if (do_susp && state_ff != flash_sr_pkg::ST_SR) begin
					nxt_state = flash_sr_pkg::ST_PAUSE;
				end else if (cnt_ff == '0) begin
					nxt_state = flash_sr_pkg::ST_IDLE;
				end else begin
					nxt_cnt = cnt_ff - 1'b1;
				end
			end
			flash_sr_pkg::ST_PAUSE: begin
				if (do_resume) begin
					nxt_state = sr_ff.esus ? flash_sr_pkg::ST_ERASE : flash_sr_pkg::ST_PROG;
				end
			end
			default: nxt_state = flash_sr_pkg::ST_IDLE;
		endcase
		if (sw_reset) begin
			nxt_state = flash_sr_pkg::ST_IDLE;
		end
	end

	// A status write lands on one byte lane; the cast lines the data up with the fields.
	always_comb begin
		wr = flash_sr_pkg::status_t'({data_ff, data_ff, data_ff});
	end

	// Power-up loads the factory state, which also drops lock mode 10 back to 00.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sr_ff <= flash_sr_pkg::SR_DEFAULT;
			state_ff <= flash_sr_pkg::ST_IDLE;
			cnt_ff <= '0;
			arm_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			if (aligned) begin
				arm_ff <= cmd_ff == flash_sr_pkg::CMD_RST_EN;
			end
			if (go_sw && cmd_ff == flash_sr_pkg::CMD_SW1) begin
				sr_ff.lock_mode_low <= wr.lock_mode_low;
				sr_ff.bp <= wr.bp;
			end
			if (go_sw && cmd_ff == flash_sr_pkg::CMD_SW2) begin
				sr_ff.lock_mode_high <= wr.lock_mode_high;
				sr_ff.qe <= wr.qe;
				sr_ff.lb <= sr_ff.lb | wr.lb;
				sr_ff.cmp <= wr.cmp;
			end
			if (go_sw && cmd_ff == flash_sr_pkg::CMD_SW3) begin
				sr_ff.drive <= wr.drive;
			end
			if (do_wren) begin
				sr_ff.write_latch_flag <= 1'b1;
			end else if (do_write_lock_cmd || busy_end || sw_reset) begin
				sr_ff.write_latch_flag <= 1'b0;
			end
			if (do_susp && state_ff == flash_sr_pkg::ST_ERASE) begin
				sr_ff.esus <= 1'b1;
			end else if (do_susp && state_ff == flash_sr_pkg::ST_PROG) begin
				sr_ff.psus <= 1'b1;
			end else if (do_resume || sw_reset) begin
				sr_ff.esus <= 1'b0;
				sr_ff.psus <= 1'b0;
			end
			if (aligned && cmd_ff == flash_sr_pkg::CMD_FAST_ON) begin
				sr_ff.fast <= 1'b1;
			end else if (aligned && cmd_ff == flash_sr_pkg::CMD_FAST_OFF) begin
				sr_ff.fast <= 1'b0;
			end
		end
	end

	// Array requests and refusals are one-cycle pulses from flops.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			op_ff <= '{kind: flash_sr_pkg::OP_NONE, addr: 24'h000000};
			refused_ff <= 1'b0;
		end else begin
			op_ff.addr <= addr_ff;
			op_ff.kind <= go_prog ? flash_sr_pkg::OP_PROG : go_erase ?
				flash_sr_pkg::OP_ERASE : go_chip ? flash_sr_pkg::OP_CHIP : flash_sr_pkg::OP_NONE;
			refused_ff <= want && !(go_sw || go_prog || go_erase || go_chip);
		end
	end

	assign so_data = so_ff;
	assign so_oe = oe_ff & ~cs_s;
	assign array_op = op_ff;
	assign op_refused = refused_ff;
	assign drive_strength = sr_ff.drive;
	assign quad_lanes_on = sr_ff.qe;
	assign security_lock_bits = sr_ff.lb;
	assign fast_mode_flag = sr_ff.fast;

	wip_busy_a: assert property (@(posedge sys_clk) disable iff (rst)
		go_sw |=> status.write_in_progress) else $error("busy bit not raised by status write");
	latch_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
		(aligned && is_prog && !sr_ff.write_latch_flag) |=> op_ff.kind == flash_sr_pkg::OP_NONE &&
		op_refused) else $error("program accepted without write latch");
	shield_refuse_a: assert property (@(posedge sys_clk) disable iff (rst)
		(aligned && is_erase && prot) |=> op_refused) else $error("erase into shield");
	lock_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
		(aligned && is_sw && sr_ff.lock_mode_high) |=> $stable(sr_ff.bp) && $stable(sr_ff.cmp))
		else $error("status written while locked");
	chip_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
		(op_ff.kind == flash_sr_pkg::OP_CHIP) |-> ($past(sr_ff.bp[2:0]) == 3'h0 &&
		!$past(sr_ff.cmp)) || ($past(sr_ff.bp[2:0]) == 3'h7 && $past(sr_ff.cmp)))
		else $error("full wipe let through");
	lb_sticky_a: assert property (@(posedge sys_clk) disable iff (rst)
		(|($past(sr_ff.lb) & ~sr_ff.lb)) == 1'b0) else $error("security lock cleared");
	pause_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
		(do_resume || sw_reset) |=> !status.esus && !status.psus)
		else $error("paused flag survived resume");
	latch_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
		do_write_lock_cmd |=> !status.write_latch_flag) else $error("write latch not cleared");
	reserved_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
		status[23] == 1'b0 && status[19:16] == 4'h0) else $error("reserved bit set");
	drive_reset_a: assert property (@(posedge sys_clk)
		rst |=> drive_strength == flash_sr_pkg::DRV_DEFAULT) else $error("drive default");
	sr_write_c: cover property (@(posedge sys_clk) disable iff (rst) go_sw ##1 status.write_in_progress);
	prog_pause_c: cover property (@(posedge sys_clk) disable iff (rst)
		go_prog ##[1:300] (state_ff == flash_sr_pkg::ST_PAUSE));
	refuse_c: cover property (@(posedge sys_clk) disable iff (rst) op_refused);
endmodule : flash_status_and_protection
